//--- core/hcd_pkg.sv
// Constants and types for the haptic two-wire command decoder
package hcd_pkg;
  localparam logic [6:0] HCD_DEV_ADDR = 7'h10;
  localparam logic [3:0] HCD_BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] HCD_CODE_LAST_EFFECT = 8'h0d;
  localparam logic [7:0] HCD_CODE_REVISION = 8'h0e;
  localparam logic [7:0] HCD_CODE_ABORT = 8'h0f;
  localparam logic [1:0] HCD_WR_BYTE_CODE = 2'h0;
  localparam logic [1:0] HCD_WR_BYTE_CHECK = 2'h1;
  localparam logic [1:0] HCD_WR_BYTE_EXTRA = 2'h2;
  // Library revision, most significant byte first; value is arbitrary
  localparam logic [15:0] HCD_REV_WORD = 16'h0102;
  localparam int HCD_CLK_PERIOD_NS = 25;
  typedef enum logic [2:0] {
    HCD_IDLE,
    HCD_ADDR,
    HCD_ADDR_ACK,
    HCD_WR,
    HCD_WR_ACK,
    HCD_RD,
    HCD_RD_ACK,
    HCD_IGNORE
  } hcd_state_e;
endpackage : hcd_pkg

//--- core/hcd_cmd_decoder.sv
// Two-wire slave that decodes haptic effect, abort and revision commands
// Summary of operation
// - The first byte after a start is seven address bits, which must be 0010000, then the direction bit.
// - An effect command is an index byte 0x00 to 0x0d followed by its check byte.
// - A selected effect starts only after the stop that ends a valid effect command.
// - Code 0x0f with check 0xf1 ends any effect in progress at the following stop.
// - Code 0x0e with check 0xf2 prepares the revision bytes and holds them for a later read.
// - A start or stop in place of a data bit abandons the command and nothing of it is used.
// - A write whose second byte fails the check against the first is discarded.
// - The device drives an acknowledge after each byte it accepts in a write and releases the line for a not-acknowledge.
// - An effect or abort command acts only once it is fully received, correctly formed and followed by stop.
// - Revision is read by start, write address, code, check, repeated start, read address.
// - The revision read sends the most significant byte first and moves on after each byte.
// - After an undefined command the data line is released and the bus ignored until a new start and address.
// - Any stop returns the bus logic to idle, ready for a new start.
// - A general call or foreign address gets no acknowledge; the own address is acknowledged for writes, and for reads only while a revision is held.
`timescale 1ns/1ps
module hcd_cmd_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Effect engine side
  output logic effect_start,
  output logic [3:0] effect_index,
  output logic effect_abort,
  output logic rev_pending
);
  import hcd_pkg::*;

  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  hcd_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic oe_n_ff;
  logic rev_ptr_ff;
  logic [1:0] wr_cnt_ff;
  logic [7:0] cmd_code_ff;
  logic cmd_ok_ff;
  logic rev_ready_ff;
  logic addr_rd_ff;
  logic start_ff, abort_ff;
  logic [3:0] index_ff;
  logic byte_done;
  logic addr_match;
  logic [7:0] check_need;
  logic [7:0] rev_byte;

  // Pins cross into the mclk domain through two flops; third stage only for edges
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  assign byte_done = scl_fall && (bit_cnt_ff == HCD_BITS_PER_BYTE);
  assign addr_match = (shift_ff[7:1] == HCD_DEV_ADDR);
  assign check_need = 8'(8'h00 - cmd_code_ff);
  assign rev_byte = rev_ptr_ff ? HCD_REV_WORD[7:0] : HCD_REV_WORD[15:8];

  // Bus sequencer; start and stop win over any bit in progress
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= HCD_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      oe_n_ff <= 1'b1;
      rev_ptr_ff <= 1'b0;
      wr_cnt_ff <= 2'h0;
      cmd_code_ff <= 8'h00;
      cmd_ok_ff <= 1'b0;
      rev_ready_ff <= 1'b0;
      addr_rd_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= HCD_IDLE;
      oe_n_ff <= 1'b1;
      cmd_ok_ff <= 1'b0;
      wr_cnt_ff <= 2'h0;
    end else if (start_det) begin
      state_ff <= HCD_ADDR;
      bit_cnt_ff <= 4'h0;
      oe_n_ff <= 1'b1;
      cmd_ok_ff <= 1'b0;
      wr_cnt_ff <= 2'h0;
    end else begin
      case (state_ff)
        HCD_ADDR, HCD_WR: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s2_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            // First rise may be the stop's own clock, so only a second one drops the command
            if (state_ff == HCD_WR && wr_cnt_ff == HCD_WR_BYTE_EXTRA &&
                bit_cnt_ff != 4'h0) begin
              cmd_ok_ff <= 1'b0;
            end
          end else if (byte_done && state_ff == HCD_ADDR) begin
            addr_rd_ff <= shift_ff[0];
            // Reads are only answered while a revision is held
            if (addr_match && (!shift_ff[0] || rev_ready_ff)) begin
              state_ff <= HCD_ADDR_ACK;
              oe_n_ff <= 1'b0;
            end else begin
              state_ff <= HCD_IGNORE;
            end
          end else if (byte_done) begin
            case (wr_cnt_ff)
              HCD_WR_BYTE_CODE: begin
                if (shift_ff <= HCD_CODE_ABORT) begin
                  cmd_code_ff <= shift_ff;
                  wr_cnt_ff <= HCD_WR_BYTE_CHECK;
                  state_ff <= HCD_WR_ACK;
                  oe_n_ff <= 1'b0;
                end else begin
                  state_ff <= HCD_IGNORE;
                end
              end
              HCD_WR_BYTE_CHECK: begin
                if (shift_ff == check_need) begin
                  cmd_ok_ff <= 1'b1;
                  wr_cnt_ff <= HCD_WR_BYTE_EXTRA;
                  state_ff <= HCD_WR_ACK;
                  oe_n_ff <= 1'b0;
                  if (cmd_code_ff == HCD_CODE_REVISION) begin
                    rev_ready_ff <= 1'b1;
                  end
                end else begin
                  state_ff <= HCD_IGNORE;
                end
              end
              default: begin
                cmd_ok_ff <= 1'b0;
                state_ff <= HCD_IGNORE;
              end
            endcase
          end
        end
        HCD_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (addr_rd_ff) begin
              // First byte out is the most significant one
              state_ff <= HCD_RD;
              tx_ff <= {HCD_REV_WORD[14:8], 1'b0};
              oe_n_ff <= HCD_REV_WORD[15];
              rev_ptr_ff <= 1'b1;
              rev_ready_ff <= 1'b0;
            end else begin
              state_ff <= HCD_WR;
              oe_n_ff <= 1'b1;
            end
          end
        end
        HCD_WR_ACK: begin
          if (scl_fall) begin
            state_ff <= HCD_WR;
            bit_cnt_ff <= 4'h0;
            oe_n_ff <= 1'b1;
          end
        end
        HCD_RD: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            state_ff <= HCD_RD_ACK;
            oe_n_ff <= 1'b1;
          end else if (scl_fall) begin
            oe_n_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
          end
        end
        HCD_RD_ACK: begin
          if (scl_rise && sda_s2_ff) begin
            state_ff <= HCD_IGNORE;
          end else if (scl_fall) begin
            // Pointer wraps so the master may read on until it stops
            state_ff <= HCD_RD;
            bit_cnt_ff <= 4'h0;
            oe_n_ff <= rev_byte[7];
            tx_ff <= {rev_byte[6:0], 1'b0};
            rev_ptr_ff <= ~rev_ptr_ff;
          end
        end
        HCD_IGNORE: begin
          oe_n_ff <= 1'b1;
        end
        default: begin
          state_ff <= HCD_IDLE;
        end
      endcase
    end
  end

  // Actions fire one cycle after the stop, never on the bytes themselves
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      index_ff <= 4'h0;
    end else begin
      start_ff <= stop_det && cmd_ok_ff && (cmd_code_ff <= HCD_CODE_LAST_EFFECT);
      abort_ff <= stop_det && cmd_ok_ff && (cmd_code_ff == HCD_CODE_ABORT);
      if (stop_det && cmd_ok_ff && (cmd_code_ff <= HCD_CODE_LAST_EFFECT)) begin
        index_ff <= cmd_code_ff[3:0];
      end
    end
  end

  // Open-drain data: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_ff;
  assign effect_start = start_ff;
  assign effect_abort = abort_ff;
  assign effect_index = index_ff;
  assign rev_pending = rev_ready_ff;

  a_effect_on_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    effect_start |-> $past(stop_det) && effect_index <= 4'hd)
    else $error("effect started without a stop");
  a_abort_on_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(effect_abort) |-> $past(stop_det) && $past(cmd_code_ff) == HCD_CODE_ABORT)
    else $error("abort not tied to stop and abort code");
  a_rev_armed: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(rev_ready_ff) |-> cmd_code_ff == HCD_CODE_REVISION && $past(shift_ff) == 8'hf2)
    else $error("revision armed by wrong bytes");
  a_start_abandons: assert property (@(posedge mclk) disable iff (sys_rst)
    start_det |=> !cmd_ok_ff && state_ff == HCD_ADDR ##1 !effect_start)
    else $error("start did not abandon command");
  a_check_match: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(cmd_ok_ff) |-> 8'($past(shift_ff) + cmd_code_ff) == 8'h00)
    else $error("command accepted with bad check byte");
  a_write_ack: assert property (@(posedge mclk) disable iff (sys_rst)
    state_ff == HCD_WR_ACK |-> !sda_oe_n)
    else $error("write byte not acknowledged");
  a_exec_needs_ok: assert property (@(posedge mclk) disable iff (sys_rst)
    (effect_start || effect_abort) |-> $past(cmd_ok_ff, 1))
    else $error("action without a valid command");
  a_read_msb: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == HCD_ADDR_ACK && scl_fall && addr_rd_ff && !stop_det && !start_det)
    |=> sda_oe_n == HCD_REV_WORD[15] && rev_ptr_ff)
    else $error("revision read did not open with the high byte");
  a_ignore_release: assert property (@(posedge mclk) disable iff (sys_rst)
    state_ff == HCD_IGNORE |=> sda_oe_n)
    else $error("data line driven while ignoring");
  a_stop_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    stop_det |=> state_ff == HCD_IDLE && sda_oe_n)
    else $error("stop did not return to idle");
  a_foreign_nack: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == HCD_ADDR && byte_done && !addr_match && !stop_det && !start_det)
    |=> state_ff == HCD_IGNORE && sda_oe_n)
    else $error("foreign address acknowledged");
  a_extra_byte: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == HCD_WR && byte_done && wr_cnt_ff == HCD_WR_BYTE_EXTRA && !stop_det)
    |=> !cmd_ok_ff ##1 !effect_start)
    else $error("third byte left command valid");
  a_partial_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_ff == HCD_WR && scl_rise && wr_cnt_ff == HCD_WR_BYTE_EXTRA && bit_cnt_ff != 4'h0)
    |=> !cmd_ok_ff)
    else $error("partial third byte left command valid");

  c_effect: cover property (@(posedge mclk) disable iff (sys_rst) effect_start);
  c_abort: cover property (@(posedge mclk) disable iff (sys_rst) effect_abort);
  c_rev_second: cover property (@(posedge mclk) disable iff (sys_rst)
    state_ff == HCD_RD_ACK && scl_fall && rev_ptr_ff);
  c_ignored: cover property (@(posedge mclk) disable iff (sys_rst) state_ff == HCD_IGNORE);
endmodule : hcd_cmd_decoder

//--- testbench/hcd_bus_master.sv
// Two-wire bus master model; released data is pulled high on the shared wire
`timescale 1ns/1ps
module hcd_bus_master (
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Clock stands high between frames; data bits move only while clock is low, start and stop move data while it is high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #50 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
    #50;
  endtask : bit_io
  task automatic start;
    sda_drv = 1'b1;
    #50 scl = 1'b1;
    #50 sda_drv = 1'b0;
    #50 scl = 1'b0;
    #50;
  endtask : start
  task automatic stop;
    sda_drv = 1'b0;
    #50 scl = 1'b1;
    #50 sda_drv = 1'b1;
    #50;
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : wr_byte
  // A high answer on the last byte tells the device the read is over
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : hcd_bus_master

//--- testbench/test_haptic_i2c_command_decoder.sv
// Self-checking bench for the haptic two-wire command decoder
`timescale 1ns/1ps
module test_haptic_i2c_command_decoder;
  import hcd_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe_n, effect_start, effect_abort, rev_pending;
  logic [3:0] effect_index;
  wire sda;
  int n_fail = 0;
  int n_checks = 0;
  int n_start = 0;
  int n_abort = 0;
  // Wire level resolved from both open-drain parties
  assign sda = sda_drv & (sda_oe_n | sda_out);
  always #12.5 mclk = ~mclk;
  hcd_cmd_decoder hcd_cmd_decoder_inst (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .effect_start(effect_start),
    .effect_index(effect_index), .effect_abort(effect_abort), .rev_pending(rev_pending));
  hcd_bus_master hcd_bus_master_inst (.sda(sda), .scl(scl), .sda_drv(sda_drv));
  always @(posedge mclk) begin
    n_start <= n_start + int'(effect_start === 1'b1);
    n_abort <= n_abort + int'(effect_abort === 1'b1);
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] code, input logic [7:0] chk, output logic [2:0] a);
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b0}, a[2]);
    hcd_bus_master_inst.wr_byte(code, a[1]);
    hcd_bus_master_inst.wr_byte(chk, a[0]);
  endtask : cmd
  // Action lands a few cycles after the stop because of the pin synchronisers
  task automatic stop_wait;
    hcd_bus_master_inst.stop();
    repeat (6) @(posedge mclk);
    // Step off the edge so pins move and results are read away from it
    #2;
  endtask : stop_wait
  task automatic t_effects;
    logic [2:0] a;
    int s;
    for (int i = 0; i <= 13; i++) begin
      s = n_start;
      cmd(8'(i), 8'(-i), a);
      check("acks", 16'(a), 16'h0);
      check("early start", 16'(n_start), 16'(s));
      stop_wait();
      check("start count", 16'(n_start), 16'(s + 1));
      check("index", 16'(effect_index), 16'(i));
    end
    $display("effects done");
  endtask : t_effects
  task automatic t_abort;
    logic [2:0] a;
    int s;
    s = n_start;
    cmd(HCD_CODE_ABORT, 8'hf1, a);
    check("abort acks", 16'(a), 16'h0);
    stop_wait();
    check("abort count", 16'(n_abort), 16'h1);
    check("abort no start", 16'(n_start), 16'(s));
    $display("abort done");
  endtask : t_abort
  task automatic t_refuse;
    logic [2:0] a;
    logic x;
    int s;
    s = n_start;
    cmd(8'h03, 8'h05, a);
    check("bad check", 16'(a), 16'h1);
    stop_wait();
    cmd(8'h20, 8'he0, a);
    check("undefined", 16'(a), 16'h3);
    stop_wait();
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte(8'h00, x);
    check("general call", 16'(x), 16'h1);
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte(8'h22, x);
    check("foreign addr", 16'(x), 16'h1);
    stop_wait();
    cmd(8'h01, 8'hff, a);
    hcd_bus_master_inst.wr_byte(8'h00, x);
    check("extra byte", 16'({a, x}), 16'h1);
    stop_wait();
    check("nothing ran", 16'(n_start), 16'(s));
    $display("refuse done");
  endtask : t_refuse
  task automatic t_abandon;
    logic [2:0] a;
    logic x;
    int s;
    s = n_start;
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b0}, x);
    hcd_bus_master_inst.wr_byte(8'h02, x);
    repeat (3) hcd_bus_master_inst.bit_io(1'b1, x);
    stop_wait();
    check("stop mid byte", 16'(n_start), 16'(s));
    cmd(8'h02, 8'hfe, a);
    repeat (3) hcd_bus_master_inst.bit_io(1'b1, x);
    stop_wait();
    check("stop in extra byte", 16'(n_start), 16'(s));
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b0}, x);
    hcd_bus_master_inst.wr_byte(8'h03, x);
    hcd_bus_master_inst.bit_io(1'b1, x);
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b0}, x);
    hcd_bus_master_inst.wr_byte(8'h05, x);
    hcd_bus_master_inst.wr_byte(8'hfb, x);
    stop_wait();
    check("restart mid byte", 16'(n_start), 16'(s + 1));
    check("index after restart", 16'(effect_index), 16'h5);
    $display("abandon done");
  endtask : t_abandon
  task automatic t_revision;
    logic [2:0] a;
    logic [7:0] d;
    logic x;
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b1}, x);
    check("read not pending", 16'(x), 16'h1);
    stop_wait();
    cmd(HCD_CODE_REVISION, 8'hf2, a);
    check("rev acks", 16'(a), 16'h0);
    check("pending set", 16'(rev_pending), 16'h1);
    hcd_bus_master_inst.start();
    hcd_bus_master_inst.wr_byte({HCD_DEV_ADDR, 1'b1}, x);
    check("read addr", 16'(x), 16'h0);
    for (int k = 0; k < 4; k++) begin
      hcd_bus_master_inst.rd_byte(k == 3, d);
      check("rev byte", 16'(d),
        16'((k % 2) ? HCD_REV_WORD[7:0] : HCD_REV_WORD[15:8]));
    end
    check("pending clear", 16'(rev_pending), 16'h0);
    stop_wait();
    check("sda released", 16'(sda_oe_n), 16'h1);
    $display("revision done");
  endtask : t_revision
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge mclk);
    #2 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    check("reset sda", 16'(sda_oe_n), 16'h1);
    t_effects();
    t_abort();
    t_refuse();
    t_abandon();
    t_revision();
    print_verdict();
  end
  // Whole run takes about 150 us; allow generous margin
  initial begin
    #600us;
    n_fail++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : test_haptic_i2c_command_decoder
